// *** include/ram_monitor_port_regs.vh ***
// constants for the ram monitor port: timing counts and command codes
// assumes plain Verilog-2005 includes by bare name
`ifndef RAM_MONITOR_PORT_REGS_VH
`define RAM_MONITOR_PORT_REGS_VH

// ----------------------------------------------------------------
// timing counts, in monitor clock rising edges
// ----------------------------------------------------------------
`define MON_INIT_CLOCKS      4'h5
`define MON_POST_RST_CLOCKS  4'h2

// ----------------------------------------------------------------
// nibble command codes
// ----------------------------------------------------------------
`define MON_CMD_READ         4'h8
`define MON_CMD_WRITE        4'ha

// ----------------------------------------------------------------
// status nibbles driven back on the data lines
// ----------------------------------------------------------------
`define MON_STAT_BUSY        4'h0
`define MON_STAT_READY       4'h1
`define MON_STAT_BUS_ERROR   4'h7

`endif

// *** logic/pin_sync.v ***
// two-flip-flop synchroniser for a bundle of asynchronous inputs
// assumes the destination clock is clock_i
`timescale 1ns/1ns
module pin_sync #(
  parameter WIDTH = 1
) (
  input  wire             clock_i,
  input  wire             sys_rst_i,
  input  wire [WIDTH-1:0] async_i,
  input  wire [WIDTH-1:0] reset_val_i,
  output reg  [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] meta_r;

  always @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      // start at the idle level of each pin so no false edge follows reset
      meta_r <= reset_val_i;
      sync_o <= reset_val_i;
    end
    else
    begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end

endmodule // pin_sync

// *** logic/ram_monitor_port.v ***
// ram monitor debug port: nibble-serial command, address and data
// assumes a single-word system bus master handshake on clock_i
// Overview of operation
// - reset low over more than five monitor clocks initializes the port
// - reset mid-transfer abandons the bus access with no recovery
// - no transfer while the device is in external or internal reset
// - a bus error from an uninitialized memory access is reported back
`timescale 1ns/1ns
`include "ram_monitor_port_regs.vh"
module ram_monitor_port #(
  parameter ADDR_NIBBLES = 8,
  parameter DATA_NIBBLES = 8
) (
  input  wire                      clock_i,
  input  wire                      sys_rst_i,
  input  wire                      monitor_clock_i,
  input  wire                      monitor_port_reset_n_i,
  input  wire                      monitor_sync_strobe_n_i,
  input  wire [3:0]                monitor_data_lines_i,
  output reg  [3:0]                monitor_data_lines_o,
  output reg                       monitor_data_lines_oe_n_o,
  input  wire                      debug_unit_reset_n_i,
  input  wire                      device_in_reset_i,
  output reg                       bus_req_o,
  output reg                       bus_write_o,
  output reg  [4*ADDR_NIBBLES-1:0] bus_addr_o,
  output reg  [4*DATA_NIBBLES-1:0] bus_wdata_o,
  input  wire                      bus_done_i,
  input  wire                      bus_error_i,
  input  wire [4*DATA_NIBBLES-1:0] bus_rdata_i,
  output reg                       port_ready_o
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  wire [6:0] pins_s;

  pin_sync #(
    .WIDTH (7)
  ) u_sync (
    .clock_i     (clock_i),
    .sys_rst_i   (sys_rst_i),
    .async_i     ({monitor_clock_i, monitor_port_reset_n_i, monitor_sync_strobe_n_i,
                   monitor_data_lines_i}),
    .reset_val_i (7'h10),
    .sync_o      (pins_s)
  );

  wire       mck_s   = pins_s[6];
  wire       prst_n  = pins_s[5];
  wire       sync_n  = pins_s[4];
  wire [3:0] din     = pins_s[3:0];

  reg  mck_d_r;
  wire mck_rise = mck_s & ~mck_d_r;

  localparam ST_UNINIT = 3'h0;
  localparam ST_POST   = 3'h1;
  localparam ST_IDLE   = 3'h2;
  localparam ST_CMD    = 3'h3;
  localparam ST_ADDR   = 3'h4;
  localparam ST_WDATA  = 3'h5;
  localparam ST_BUS    = 3'h6;
  localparam ST_RDATA  = 3'h7;

  reg [2:0] state_r;
  reg [3:0] init_cnt_r;
  reg [3:0] post_cnt_r;
  reg [3:0] cmd_r;
  reg [5:0] nib_r;
  reg [4*DATA_NIBBLES-1:0] rdata_r;
  reg       err_r;

  function is_cmd;
    input [3:0] c;
    begin
      is_cmd = (c == `MON_CMD_READ) || (c == `MON_CMD_WRITE);
    end
  endfunction

  wire blocked = device_in_reset_i | ~debug_unit_reset_n_i;

  // ----------------------------------------------------------------
  // port sequencing
  // ----------------------------------------------------------------
  always @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      mck_d_r                   <= 1'b0;
      state_r                   <= ST_UNINIT;
      init_cnt_r                <= 4'h0;
      post_cnt_r                <= 4'h0;
      cmd_r                     <= 4'h0;
      nib_r                     <= 6'h00;
      rdata_r                   <= {4*DATA_NIBBLES{1'b0}};
      err_r                     <= 1'b0;
      bus_req_o                 <= 1'b0;
      bus_write_o               <= 1'b0;
      bus_addr_o                <= {4*ADDR_NIBBLES{1'b0}};
      bus_wdata_o               <= {4*DATA_NIBBLES{1'b0}};
      monitor_data_lines_o      <= `MON_STAT_BUSY;
      monitor_data_lines_oe_n_o <= 1'b1;
      port_ready_o              <= 1'b0;
    end
    else
    begin
      mck_d_r <= mck_s;
      if (!prst_n)
      begin
        // reset abandons any access in flight
        state_r                   <= ST_UNINIT;
        bus_req_o                 <= 1'b0;
        monitor_data_lines_oe_n_o <= 1'b1;
        port_ready_o              <= 1'b0;
        post_cnt_r                <= 4'h0;
        if (mck_rise && init_cnt_r <= `MON_INIT_CLOCKS)
          init_cnt_r <= init_cnt_r + 4'h1;
      end
      else if (mck_rise)
      begin
        case (state_r)
          ST_UNINIT:
          begin
            // need more than five clocks under reset
            if (init_cnt_r > `MON_INIT_CLOCKS)
              state_r <= ST_POST;
            init_cnt_r <= 4'h0;
          end
          ST_POST:
          begin
            // strobe and data ignored until post-reset clocks pass
            post_cnt_r <= post_cnt_r + 4'h1;
            if (post_cnt_r >= `MON_POST_RST_CLOCKS)
            begin
              state_r      <= ST_IDLE;
              port_ready_o <= 1'b1;
            end
          end
          ST_IDLE:
          begin
            monitor_data_lines_oe_n_o <= 1'b1;
            if (!sync_n && !blocked && is_cmd(din))
            begin
              cmd_r   <= din;
              nib_r   <= 6'h00;
              err_r   <= 1'b0;
              state_r <= ST_ADDR;
            end
          end
          ST_ADDR:
          begin
            bus_addr_o <= {bus_addr_o[4*ADDR_NIBBLES-5:0], din};
            nib_r      <= nib_r + 6'h01;
            if (sync_n)
              state_r <= ST_IDLE;
            else if (nib_r == ADDR_NIBBLES - 1)
            begin
              nib_r   <= 6'h00;
              state_r <= (cmd_r == `MON_CMD_WRITE) ? ST_WDATA : ST_BUS;
            end
          end
          ST_WDATA:
          begin
            bus_wdata_o <= {bus_wdata_o[4*DATA_NIBBLES-5:0], din};
            nib_r       <= nib_r + 6'h01;
            if (sync_n)
              state_r <= ST_IDLE;
            else if (nib_r == DATA_NIBBLES - 1)
              state_r <= ST_BUS;
          end
          ST_RDATA:
          begin
            monitor_data_lines_o <= rdata_r[4*DATA_NIBBLES-1 -: 4];
            rdata_r              <= {rdata_r[4*DATA_NIBBLES-5:0], 4'h0};
            nib_r                <= nib_r + 6'h01;
            if (sync_n || nib_r == DATA_NIBBLES)
            begin
              monitor_data_lines_oe_n_o <= 1'b1;
              state_r                   <= ST_IDLE;
            end
          end
          ST_BUS:
          begin
            monitor_data_lines_oe_n_o <= 1'b0;
            if (!bus_req_o && !err_r && nib_r != 6'h3f)
            begin
              monitor_data_lines_o <= `MON_STAT_BUSY;
              if (!blocked)
              begin
                bus_req_o   <= 1'b1;
                bus_write_o <= (cmd_r == `MON_CMD_WRITE);
              end
            end
            else if (err_r)
              monitor_data_lines_o <= `MON_STAT_BUS_ERROR;
            else if (nib_r == 6'h3f)
            begin
              // ready shown; on a write, strobe released by tool one clock later
              monitor_data_lines_o <= `MON_STAT_READY;
              if (cmd_r == `MON_CMD_READ)
              begin
                nib_r   <= 6'h00;
                state_r <= ST_RDATA;
              end
            end
            // strobe released after the status: release the lines and go idle
            if (sync_n && (err_r || nib_r == 6'h3f))
            begin
              monitor_data_lines_oe_n_o <= 1'b1;
              state_r                   <= ST_IDLE;
            end
          end
          default:
            state_r <= ST_UNINIT;
        endcase
      end

      // bus completion is taken on any system clock
      if (prst_n && state_r == ST_BUS && bus_req_o && bus_done_i)
      begin
        bus_req_o <= 1'b0;
        rdata_r   <= bus_rdata_i;
        err_r     <= bus_error_i;
        nib_r     <= bus_error_i ? 6'h00 : 6'h3f;
      end
    end
  end

endmodule // ram_monitor_port

// *** bench/ram_monitor_port_sva.sv ***
// checker: ram monitor port outputs tied to their causes at the inputs
// assumes a bind from the bench top onto ram_monitor_port
`timescale 1ns/1ns
`include "ram_monitor_port_regs.vh"
module ram_monitor_port_sva (
  input wire       clock_i,
  input wire       sys_rst_i,
  input wire       monitor_port_reset_n_i,
  input wire       device_in_reset_i,
  input wire [3:0] monitor_data_lines_o,
  input wire       monitor_data_lines_oe_n_o,
  input wire       bus_req_o,
  input wire       bus_done_i,
  input wire       bus_error_i,
  input wire       port_ready_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (sys_rst_i);
  a_ready_after_release:
    assert property ($rose(port_ready_o) |-> monitor_port_reset_n_i)
    else $error("ready rose while port reset low");
  a_reset_clears_ready:
    assert property ($fell(monitor_port_reset_n_i) |-> ##6 !port_ready_o)
    else $error("ready stayed high after port reset");
  a_reset_drops_req:
    assert property (!monitor_port_reset_n_i [*8] |-> !bus_req_o)
    else $error("bus request kept during port reset");
  a_blocked_no_req:
    assert property (device_in_reset_i [*4] |-> !$rose(bus_req_o))
    else $error("bus request raised during device reset");
  a_req_needs_ready:
    assert property ($rose(bus_req_o) |-> port_ready_o)
    else $error("bus request before port ready");
  a_error_status:
    assert property (bus_done_i && bus_error_i |-> ##[1:30]
      (!monitor_data_lines_oe_n_o && monitor_data_lines_o == `MON_STAT_BUS_ERROR))
    else $error("bus error not returned on data lines");
  a_ready_status:
    assert property (bus_done_i && !bus_error_i |-> ##[1:30]
      (!monitor_data_lines_oe_n_o && monitor_data_lines_o == `MON_STAT_READY))
    else $error("ready status not returned on data lines");
  c_ready: cover property ($rose(port_ready_o));
  c_error: cover property (bus_done_i && bus_error_i);
  c_abort: cover property (bus_req_o && !monitor_port_reset_n_i);
endmodule // ram_monitor_port_sva

// *** bench/monitor_tool_model.sv ***
// tool side model: monitor clock, port reset, strobe and nibble lines
// assumes the bench calls one task at a time
`timescale 1ns/1ns
`include "ram_monitor_port_regs.vh"
module monitor_tool_model (
  input  wire [3:0] dev_d_i,
  input  wire       dev_oe_n_i,
  output reg        mclk_o,
  output reg        rst_n_o,
  output reg        sync_n_o,
  output wire [3:0] line_o
);
  reg [3:0] d_r;
  reg       drv_r;
  // a released line shows the inverse of the last nibble
  assign line_o = !dev_oe_n_i ? dev_d_i : (drv_r ? d_r : ~d_r);
  initial
  begin
    mclk_o = 1'b0;
    rst_n_o = 1'b0;
    sync_n_o = 1'b1;
    d_r = 4'h0;
    drv_r = 1'b0;
  end
  task tick;
  begin
    #40 mclk_o = 1'b1;
    #40 mclk_o = 1'b0;
  end
  endtask
  task init(input integer n);
  begin
    rst_n_o = 1'b0; // only called between frames, strobe high
    repeat (n) tick;
    rst_n_o = 1'b1;
    repeat (4) tick;
  end
  endtask
  task nib(input [3:0] v);
  begin
    d_r = v;
    drv_r = 1'b1;
    tick;
  end
  endtask
  task frame(input [3:0] c, input [31:0] a, input [31:0] w, input ab,
             output [3:0] st, output [31:0] rd);
    integer i;
  begin
    sync_n_o = 1'b0;
    nib(c);
    for (i = 7; i >= 0; i = i - 1)
      nib(a[4*i+:4]);
    if (c == `MON_CMD_WRITE)
      for (i = 7; i >= 0; i = i - 1)
        nib(w[4*i+:4]);
    drv_r = 1'b0;
    st = `MON_STAT_BUSY;
    rd = 32'h0;
    for (i = 0; i < 30 && st == `MON_STAT_BUSY; i = i + 1)
    begin
      tick;
      rst_n_o = !ab;
      st = dev_oe_n_i ? `MON_STAT_BUSY : dev_d_i;
    end
    if (st == `MON_STAT_READY && c == `MON_CMD_READ)
      for (i = 7; i >= 0; i = i - 1)
      begin
        tick;
        rd[4*i+:4] = dev_d_i;
      end
    tick;
    sync_n_o = 1'b1;
    tick; // strobe seen high before the next frame
  end
  endtask
endmodule // monitor_tool_model

// *** bench/testbench.sv ***
// top bench: ram monitor port against the tool model and a bus slave
// assumes the design, tool model and checker are compiled first
`timescale 1ns/1ns
`include "ram_monitor_port_regs.vh"
module testbench;
  localparam [31:0] adr_c = 32'h8000_fffc;
  localparam [31:0] wdt_c = 32'h5a5a_0ff0;
  reg         clock_i, sys_rst_i, dev_rst, dbg_n, done, berr, cap_we;
  reg  [31:0] rdat, cap_a, cap_w, rd;
  reg  [3:0]  st;
  integer     lat, cnt, n, nreq, err_total, samples_checked;
  wire        mclk, prst_n, sync_n, oe_n, req, we, rdy;
  wire [3:0]  line, dout;
  wire [31:0] addr, wdat;
  ram_monitor_port i_ram_monitor_port (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .monitor_clock_i(mclk), .monitor_port_reset_n_i(prst_n), .monitor_sync_strobe_n_i(sync_n),
    .monitor_data_lines_i(line), .monitor_data_lines_o(dout), .monitor_data_lines_oe_n_o(oe_n),
    .debug_unit_reset_n_i(dbg_n), .device_in_reset_i(dev_rst), .bus_req_o(req),
    .bus_write_o(we), .bus_addr_o(addr), .bus_wdata_o(wdat), .bus_done_i(done),
    .bus_error_i(berr), .bus_rdata_i(rdat), .port_ready_o(rdy));
  monitor_tool_model i_monitor_tool_model (.dev_d_i(dout), .dev_oe_n_i(oe_n), .mclk_o(mclk),
    .rst_n_o(prst_n), .sync_n_o(sync_n), .line_o(line));
  initial
  begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end
  // bus slave: answers a held request after lat+1 cycles
  initial
  forever
  begin
    @(posedge clock_i);
    #1 done = 1'b0;
    cnt = req ? cnt + 1 : 0;
    if (cnt > lat)
    begin
      done = 1'b1;
      cnt = 0;
      nreq = nreq + 1;
      cap_a = addr;
      cap_w = wdat;
      cap_we = we;
    end
  end
  task chk(input [31:0] got, input [31:0] exp);
  begin
    samples_checked = samples_checked + 1;
    if (got !== exp)
    begin
      err_total = err_total + 1;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  end
  endtask
  task run(input [3:0] c, input ab);
    i_monitor_tool_model.frame(c, adr_c, wdt_c, ab, st, rd);
  endtask
  task t_init;
  begin
    i_monitor_tool_model.init(3);
    run(`MON_CMD_READ, 1'b0);
    chk(nreq, 0);
    chk(rdy, 1'b0);
    i_monitor_tool_model.init(6);
    chk(rdy, 1'b1);
  end
  endtask
  task t_write;
  begin
    lat = 0;
    run(`MON_CMD_WRITE, 1'b0);
    chk(st, `MON_STAT_READY);
    chk(cap_a, adr_c);
    chk(cap_w, wdt_c);
    chk(cap_we, 1'b1);
    chk(oe_n, 1'b1);
  end
  endtask
  task t_read(input e);
  begin
    lat = 40;
    berr = e;
    rdat = 32'hc3a5_7e01;
    run(`MON_CMD_READ, 1'b0);
    chk(st, e ? `MON_STAT_BUS_ERROR : `MON_STAT_READY);
    chk(rd, e ? 32'h0 : rdat);
    chk(oe_n, 1'b1);
    berr = 1'b0;
  end
  endtask
  task t_blocked;
  begin
    n = nreq;
    @(posedge clock_i) #1 dev_rst = 1'b1;
    run(`MON_CMD_READ, 1'b0);
    @(posedge clock_i) #1 dev_rst = 1'b0;
    dbg_n = 1'b0;
    run(`MON_CMD_WRITE, 1'b0);
    @(posedge clock_i) #1 dbg_n = 1'b1;
    chk(nreq, n);
  end
  endtask
  task t_abort;
  begin
    lat = 2000;
    n = nreq;
    run(`MON_CMD_READ, 1'b1);
    chk(req, 1'b0);
    chk(nreq, n);
    chk(rdy, 1'b0);
  end
  endtask
  task end_sim;
  begin
    $display("comparisons %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask
  initial
  begin
    #200000;
    err_total = err_total + 1;
    end_sim;
  end
  initial
  begin
    sys_rst_i = 1'b1;
    dev_rst = 1'b0;
    dbg_n = 1'b0;
    done = 1'b0;
    berr = 1'b0;
    rdat = 32'h0;
    lat = 0;
    cnt = 0;
    nreq = 0;
    err_total = 0;
    samples_checked = 0;
    repeat (10) @(posedge clock_i);
    #1 sys_rst_i = 1'b0;
    dbg_n = 1'b1;
    t_init;
    t_write;
    t_read(1'b0);
    t_read(1'b1);
    t_blocked;
    t_abort;
    end_sim;
  end
endmodule // testbench
bind ram_monitor_port ram_monitor_port_sva i_ram_monitor_port_sva (.clock_i(clock_i),
  .sys_rst_i(sys_rst_i), .monitor_port_reset_n_i(monitor_port_reset_n_i),
  .device_in_reset_i(device_in_reset_i), .monitor_data_lines_o(monitor_data_lines_o),
  .monitor_data_lines_oe_n_o(monitor_data_lines_oe_n_o), .bus_req_o(bus_req_o),
  .bus_done_i(bus_done_i), .bus_error_i(bus_error_i), .port_ready_o(port_ready_o));
